//--- design/irq_ctrl_pkg.sv
// Shared constants and carriers for the vectored interrupt controller
package irq_ctrl_pkg;
	localparam int NUM_SRC = 32;
	localparam int SRC_W = 5;
	localparam int PRIO_FIELD_W = 8;
	localparam int PRIO_W = 3;
	localparam int PRIO_LSB = PRIO_FIELD_W - PRIO_W;
	localparam int GROUP_W = 3;
	localparam int DEPTH_W = 6;
	localparam int ADDR_W = 32;
	localparam int VEC_STRIDE = 4;
	localparam logic [ADDR_W-1:0] VEC_BASE_RST = 32'h0000_0040;
	localparam logic [PRIO_W-1:0] PRIO_ZERO = 3'h0;
	localparam logic [DEPTH_W-1:0] DEPTH_ZERO = 6'h00;
	localparam logic [DEPTH_W-1:0] DEPTH_ONE = 6'h01;

	// Software command to the controller, one per cycle
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_ENABLE,
		CMD_DISABLE,
		CMD_PEND_SET,
		CMD_PEND_CLEAR,
		CMD_SET_PRIO,
		CMD_SET_GROUP,
		CMD_SET_THRESH
	} cmd_e;

	typedef struct packed {
		cmd_e op;
		logic [SRC_W-1:0] src;
		logic [PRIO_FIELD_W-1:0] value;
	} cmd_s;

	// Request from controller to core
	typedef struct packed {
		logic valid;
		logic [SRC_W-1:0] src;
		logic [ADDR_W-1:0] handler;
	} irq_req_s;
endpackage

//--- design/nested_vectored_irq_ctrl.sv
// Prioritizing vectored interrupt controller for 32 sources
module nested_vectored_irq_ctrl #(
	parameter int NSRC = irq_ctrl_pkg::NUM_SRC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [NSRC-1:0] i_irq,
	input wire irq_ctrl_pkg::cmd_s i_cmd,
	input wire logic i_global_mask,
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] i_vec_base,
	input wire logic i_core_ack,
	input wire logic i_core_ret,
	output irq_ctrl_pkg::irq_req_s o_irq_req,
	output logic o_in_handler,
	output logic o_may_exit,
	output logic [irq_ctrl_pkg::DEPTH_W-1:0] o_nest_depth,
	output logic [NSRC-1:0] o_pending,
	output logic [NSRC-1:0] o_active
);
	localparam int PW = irq_ctrl_pkg::PRIO_W;

	// Core handshake, as seen from here:
	//   request is a registered level, refreshed every cycle
	//   an ack on a valid cycle takes the presented source
	//   valid drops for one cycle after each ack
	//   a return pops one nesting level; ignored at depth zero
	//   a return in the same cycle as an ack is ignored
	// Why the one-cycle gap: the winner is rescanned from
	// the updated pending and active sets before it is shown again,
	// so a taken source is never offered twice.
	// Grouping: setting g keeps the top g level bits for
	// preemption; the rest only order tail-chained requests.
	// Threshold zero means no level masking at all.
	// Global mask gates the request line and nothing else.
	// Depth counter is wide enough for every source nested,
	// since an active source is never eligible again.
	// Limitation: source edges are caught against the previous
	// cycle only; a pulse shorter than one clock may be lost.
	// Limitation: a return clears every active source of the
	// returning level, so equal levels never stack on one another.
	// Trade-off: the full scan is one long compare chain;
	// cheap in flip-flops, but it sets the clock limit.

	// Preempt part of a level: subpriority bits forced to zero
	function automatic logic [PW-1:0] preempt_of(input logic [PW-1:0] p, input logic [PW-1:0] grp);
		logic [PW-1:0] m;
		m = '1;
		if (grp < PW[PW-1:0])
			m = m << (PW[PW-1:0] - grp);
		return p & m;
	endfunction

	// Level kept from a priority byte: only its top bits take part
	function automatic logic [PW-1:0] prio_level(input logic [irq_ctrl_pkg::PRIO_FIELD_W-1:0] v);
		return v[irq_ctrl_pkg::PRIO_FIELD_W-1:irq_ctrl_pkg::PRIO_LSB];
	endfunction

	// Per-source state: mask, pending, in service, last input level
	logic [NSRC-1:0] enable_q, enable_d;
	logic [NSRC-1:0] pend_q, pend_d;
	logic [NSRC-1:0] active_q, active_d;
	logic [NSRC-1:0] irq_q;

	// Per-source level and the two global settings
	logic [PW-1:0] prio_q [NSRC], prio_d [NSRC];
	logic [PW-1:0] group_q, group_d;
	logic [PW-1:0] thresh_q, thresh_d;

	// Nesting record: depth and the level run at each depth
	logic [irq_ctrl_pkg::DEPTH_W-1:0] depth_q, depth_d;
	logic [PW-1:0] run_prio_q [NSRC+1], run_prio_d [NSRC+1];

	// Registered request to the core
	irq_ctrl_pkg::irq_req_s req_q, req_d;

	logic [NSRC-1:0] eligible;
	logic win_valid;
	logic [irq_ctrl_pkg::SRC_W-1:0] win_src;
	logic [PW-1:0] win_prio;

	// Eligible: pending, enabled, not active, under threshold; peripheral enables live outside
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			eligible[i] = pend_q[i] && enable_q[i] && !active_q[i]
				&& (thresh_q == irq_ctrl_pkg::PRIO_ZERO || prio_q[i] < thresh_q);
		end
	end

	// Strict less-than scan from index 0 so ties keep the lower number
	// One compare per source across all levels
	always_comb begin
		win_valid = 1'b0;
		win_src = '0;
		win_prio = '1;
		for (int i = 0; i < NSRC; i++) begin
			if (eligible[i] && (!win_valid || prio_q[i] < win_prio)) begin
				win_valid = 1'b1;
				win_src = i[irq_ctrl_pkg::SRC_W-1:0];
				win_prio = prio_q[i];
			end
		end
	end

	// Preempt only on strictly better preempt group; equal group waits to tail-chain
	logic can_take;
	always_comb begin
		if (depth_q == irq_ctrl_pkg::DEPTH_ZERO)
			can_take = win_valid;
		else
			can_take = win_valid && (preempt_of(win_prio, group_q)
				< preempt_of(run_prio_q[depth_q], group_q));
	end

	// Table offset of the winner, cut to the address width on purpose
	logic [irq_ctrl_pkg::ADDR_W-1:0] win_offset;
	always_comb begin
		win_offset = irq_ctrl_pkg::ADDR_W'(win_src) * irq_ctrl_pkg::ADDR_W'(irq_ctrl_pkg::VEC_STRIDE);
	end

	// Next-state for configuration, pending, nesting and request
	always_comb begin
		enable_d = enable_q;
		pend_d = pend_q | (i_irq & ~irq_q);
		active_d = active_q;
		prio_d = prio_q;
		group_d = group_q;
		thresh_d = thresh_q;
		depth_d = depth_q;
		run_prio_d = run_prio_q;
		req_d = req_q;

		// Software command; one per cycle, but an acceptance below overrides its pending write to the taken source
		unique case (i_cmd.op)
			irq_ctrl_pkg::CMD_NONE: ;
			irq_ctrl_pkg::CMD_ENABLE: enable_d[i_cmd.src] = 1'b1;
			irq_ctrl_pkg::CMD_DISABLE: enable_d[i_cmd.src] = 1'b0;
			irq_ctrl_pkg::CMD_PEND_SET: pend_d[i_cmd.src] = 1'b1;
			irq_ctrl_pkg::CMD_PEND_CLEAR: pend_d[i_cmd.src] = i_irq[i_cmd.src] & ~irq_q[i_cmd.src];
			irq_ctrl_pkg::CMD_SET_PRIO: prio_d[i_cmd.src] = prio_level(i_cmd.value);
			irq_ctrl_pkg::CMD_SET_GROUP: group_d = i_cmd.value[PW-1:0];
			irq_ctrl_pkg::CMD_SET_THRESH: thresh_d = prio_level(i_cmd.value);
		endcase
		// Acceptance: push nesting record, drop pending of taken source
		if (req_q.valid && i_core_ack) begin
			pend_d[req_q.src] = i_irq[req_q.src] & ~irq_q[req_q.src];
			active_d[req_q.src] = 1'b1;
			depth_d = depth_q + irq_ctrl_pkg::DEPTH_ONE;
			run_prio_d[depth_d] = prio_q[req_q.src];
		end else if (i_core_ret && depth_q != irq_ctrl_pkg::DEPTH_ZERO) begin
			// Return: pop one level, free every source run at it
			depth_d = depth_q - irq_ctrl_pkg::DEPTH_ONE;
			for (int i = 0; i < NSRC; i++) begin
				if (active_q[i] && prio_q[i] == run_prio_q[depth_q]) begin
					active_d[i] = 1'b0;
				end
			end
		end
		// Request refreshed every cycle; global mask gates only this line
		req_d.valid = can_take && !i_global_mask && !(req_q.valid && i_core_ack);
		// Source and handler follow the winner even while masked
		req_d.src = win_src;
		req_d.handler = i_vec_base + win_offset;
	end

	// State registers, all cleared by reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_q <= '0;
			pend_q <= '0;
			active_q <= '0;
			irq_q <= '0;
			group_q <= irq_ctrl_pkg::PRIO_ZERO;
			thresh_q <= irq_ctrl_pkg::PRIO_ZERO;
			depth_q <= irq_ctrl_pkg::DEPTH_ZERO;
			req_q <= '0;
			for (int i = 0; i < NSRC; i++) begin
				prio_q[i] <= irq_ctrl_pkg::PRIO_ZERO;
			end
			for (int i = 0; i <= NSRC; i++) begin
				run_prio_q[i] <= irq_ctrl_pkg::PRIO_ZERO;
			end
		end else begin
			enable_q <= enable_d;
			pend_q <= pend_d;
			active_q <= active_d;
			irq_q <= i_irq;
			group_q <= group_d;
			thresh_q <= thresh_d;
			depth_q <= depth_d;
			req_q <= req_d;
			prio_q <= prio_d;
			run_prio_q <= run_prio_d;
		end
	end

	// Exit permitted only at depth one with nothing eligible
	// Exit flag is combinational so a late pending still blocks it
	assign o_irq_req = req_q;
	assign o_nest_depth = depth_q;
	assign o_in_handler = depth_q != irq_ctrl_pkg::DEPTH_ZERO;
	assign o_may_exit = depth_q == irq_ctrl_pkg::DEPTH_ONE && !win_valid;
	assign o_pending = pend_q;
	assign o_active = active_q;
endmodule

//--- bench/irq_props.sv
// Port checker for the vectored interrupt controller
module irq_props (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_global_mask,
	input wire logic [31:0] i_vec_base,
	input wire logic i_core_ack,
	input wire logic i_core_ret,
	input wire irq_ctrl_pkg::irq_req_s o_irq_req,
	input wire logic o_in_handler,
	input wire logic o_may_exit,
	input wire logic [5:0] o_nest_depth,
	input wire logic [31:0] o_pending,
	input wire logic [31:0] o_active
);
	// Accepted request and counted return, as the core sees them
	wire v = o_irq_req.valid;
	wire tk = v & i_core_ack;
	wire rt = i_core_ret & !tk & (o_nest_depth != 6'h00);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	property p_vec; v |-> o_irq_req.handler == i_vec_base + {o_irq_req.src, 2'h0}; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_gm; i_global_mask && $past(i_global_mask) |-> !v; endproperty
	a_gm: assert property (p_gm) else $error("mask leak");
	property p_drop; tk |=> !v; endproperty
	a_drop: assert property (p_drop) else $error("valid held");
	property p_act; tk |=> o_active[$past(o_irq_req.src)] && !o_pending[$past(o_irq_req.src)]; endproperty
	a_act: assert property (p_act) else $error("accept state");
	property p_up; tk |=> o_nest_depth == $past(o_nest_depth) + 6'h01; endproperty
	a_up: assert property (p_up) else $error("depth up");
	property p_dn; rt |=> o_nest_depth == $past(o_nest_depth) - 6'h01; endproperty
	a_dn: assert property (p_dn) else $error("depth down");
	property p_in; o_nest_depth == 6'h00 && !tk |=> !o_in_handler; endproperty
	a_in: assert property (p_in) else $error("idle flag");
	property p_ex; o_may_exit |-> o_nest_depth == 6'h01; endproperty
	a_ex: assert property (p_ex) else $error("early exit");
endmodule

bind nested_vectored_irq_ctrl irq_props u_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_global_mask(i_global_mask), .i_vec_base(i_vec_base), .i_core_ack(i_core_ack),
	.i_core_ret(i_core_ret), .o_irq_req(o_irq_req), .o_in_handler(o_in_handler), .o_may_exit(o_may_exit),
	.o_nest_depth(o_nest_depth), .o_pending(o_pending), .o_active(o_active));

//--- bench/core_model.sv
// Behavioural core that takes vectored requests
module core_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire irq_ctrl_pkg::irq_req_s i_req,
	input wire logic i_hold,
	input wire logic i_ret_req,
	output logic o_ack,
	output logic o_ret
);
	// Ack never twice in a row, so each request is taken once; hold stalls
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack <= 1'h0;
			o_ret <= 1'h0;
		end else begin
			o_ack <= i_req.valid & !o_ack & !i_hold;
			o_ret <= i_ret_req;
		end
	end
endmodule

//--- bench/tb.sv
// Self-checking bench for the interrupt controller
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 0, i_rst_n = 0, i_global_mask = 0, hold = 1, ret = 0, ack, cret, inh, mex;
	logic [31:0] i_irq = 0, pend, act;
	logic [5:0] dep;
	irq_ctrl_pkg::cmd_s i_cmd = '0;
	irq_ctrl_pkg::irq_req_s req;
	int fails = 0, n_checks = 0;
	localparam logic [31:0] BASE = 32'h0000_1000;
	always #12.5 i_ref_clk = ~i_ref_clk;
	nested_vectored_irq_ctrl uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_irq(i_irq), .i_cmd(i_cmd),
		.i_global_mask(i_global_mask), .i_vec_base(BASE), .i_core_ack(ack), .i_core_ret(cret), .o_irq_req(req),
		.o_in_handler(inh), .o_may_exit(mex), .o_nest_depth(dep), .o_pending(pend), .o_active(act));
	core_model core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(req), .i_hold(hold),
		.i_ret_req(ret), .o_ack(ack), .o_ret(cret));
	task chk(string n, logic [31:0] e, logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// One command, then room for pending and request to settle
	task cmd(irq_ctrl_pkg::cmd_e op, logic [4:0] s, logic [7:0] v);
		@(posedge i_ref_clk) i_cmd <= '{op, s, v};
		@(posedge i_ref_clk) i_cmd <= '0;
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask
	task go;
		@(posedge i_ref_clk) hold <= 0;
		repeat (3) @(posedge i_ref_clk);
		hold <= 1;
		#1;
	endtask
	task rt;
		@(posedge i_ref_clk) ret <= 1;
		@(posedge i_ref_clk) ret <= 0;
		repeat (3) @(posedge i_ref_clk);
		#1;
	endtask
	task finish_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#50us;
		fails++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1;
		for (int i = 0; i < 32; i++) cmd(irq_ctrl_pkg::CMD_ENABLE, i[4:0], 8'h00);
		// Simultaneous equal-priority edges
		@(posedge i_ref_clk) i_irq <= 32'h0000_0028;
		repeat (3) @(posedge i_ref_clk);
		#1;
		chk("src", 3, req.src);
		chk("vec", BASE + 12, req.handler);
		go;
		chk("act", 32'h0000_0008, act);
		chk("valid", 0, req.valid);
		rt;
		chk("src", 5, req.src);
		go;
		rt;
		$display("tie done");
		// Threshold, global mask and preemption; all level bits preempt
		cmd(irq_ctrl_pkg::CMD_SET_GROUP, 5'h00, 8'h03);
		cmd(irq_ctrl_pkg::CMD_SET_PRIO, 5'h07, 8'hBF);
		cmd(irq_ctrl_pkg::CMD_SET_PRIO, 5'h09, 8'h20);
		cmd(irq_ctrl_pkg::CMD_SET_THRESH, 5'h00, 8'h60);
		cmd(irq_ctrl_pkg::CMD_PEND_SET, 5'h07, 8'h00);
		chk("valid", 0, req.valid);
		cmd(irq_ctrl_pkg::CMD_SET_THRESH, 5'h00, 8'h00);
		chk("src", 7, req.src);
		go;
		@(posedge i_ref_clk) i_global_mask <= 1;
		cmd(irq_ctrl_pkg::CMD_PEND_SET, 5'h09, 8'h00);
		chk("valid", 0, req.valid);
		chk("pend", 32'h0000_0200, pend);
		@(posedge i_ref_clk) i_global_mask <= 0;
		repeat (2) @(posedge i_ref_clk);
		#1;
		chk("src", 9, req.src);
		go;
		chk("depth", 2, dep);
		rt;
		chk("exit", 1, mex);
		chk("inh", 1, inh);
		rt;
		$display("prio done");
		// Disabled pend, pend clear, no-preempt grouping
		cmd(irq_ctrl_pkg::CMD_DISABLE, 5'h09, 8'h00);
		cmd(irq_ctrl_pkg::CMD_PEND_SET, 5'h09, 8'h00);
		chk("valid", 0, req.valid);
		cmd(irq_ctrl_pkg::CMD_PEND_CLEAR, 5'h09, 8'h00);
		chk("pend", 0, pend);
		cmd(irq_ctrl_pkg::CMD_SET_GROUP, 5'h00, 8'h00);
		cmd(irq_ctrl_pkg::CMD_PEND_SET, 5'h07, 8'h00);
		go;
		cmd(irq_ctrl_pkg::CMD_ENABLE, 5'h09, 8'h00);
		cmd(irq_ctrl_pkg::CMD_PEND_SET, 5'h09, 8'h00);
		chk("valid", 0, req.valid);
		rt;
		chk("src", 9, req.src);
		go;
		rt;
		chk("depth", 0, dep);
		$display("group done");
		finish_test;
	end
endmodule
